// ### event_enable_zx_threshold_regs.sv
// Purpose: Event enables, zero-crossing setup and warning thresholds of the metering core
// Assumes: Register port and measurement inputs are on i_sys_clk; reads answer next cycle
// Notes: Status word b is read-clear; a set in the clearing cycle survives
// Function
// - Enable bit 15 gates sampled-neutral overcurrent flag onto the interrupt.
// - Enable bit 14 gates calculated-neutral overcurrent flag onto the interrupt.
// - Enable bit 11 gates voltage distortion over-threshold flag onto the interrupt.
// - Enable bit 10 gates current distortion over-threshold flag onto the interrupt.
// - Enable bit 9 gates harmonic result ready flag onto the interrupt.
// - Enable bits 7..0 gate matching energy direction change flags.
// - Enable register at 04h, read/write, resets zero, bits 13:12 and 8 reserved.
// - Interrupt pin asserts while any status bit and its enable are set.
// - Three-bit source: 000-010 voltages, 100-110 currents, 011/111 fixed zero.
// - Two-bit mode: positive, negative, all, or no crossing output.
// - Config bit 0 holds all crossing outputs low; config resets to 0001h.
// - Sag threshold at 08h, read/write 16 bits, resets zero.
// - Sag flag set when any phase voltage falls below sag threshold.
// - Phase loss threshold at 09h, read/write 16 bits, resets zero.
// - Calculated neutral rms strictly above its threshold sets status bit 14.
// - Sampled neutral rms strictly above its threshold sets status bit 15.
// - Neutral thresholds at 0Ah and 0Bh, read/write, reset to FFFFh.
`timescale 1ns/1ps
module event_enable_zx_threshold_regs (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Register port
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  output logic [15:0] o_reg_rdata,
  output logic o_reg_rvalid,
  // Measurement results, one strobe per update
  input wire logic i_rms_valid,
  input wire logic [15:0] i_volt_rms_a,
  input wire logic [15:0] i_volt_rms_b,
  input wire logic [15:0] i_volt_rms_c,
  input wire logic [15:0] i_neutral_calc_rms,
  input wire logic [15:0] i_neutral_sampled_rms,
  // Event pulses from the analysis engines
  input wire logic i_voltage_distortion_over,
  input wire logic i_current_distortion_over,
  input wire logic i_harmonic_result_ready,
  input wire logic [7:0] i_dir_change,
  // Wave signs for zero crossing, 1 means negative
  input wire logic [5:0] i_wave_sign,
  // Outputs
  output logic o_irq_out_b,
  output logic o_undervoltage_flag,
  output logic o_phase_loss_flag,
  output logic [2:0] o_zc
);
  logic [15:0] enable_reg;
  logic [15:0] enable_next;
  logic [15:0] zc_cfg_reg;
  logic [15:0] zc_cfg_next;
  logic [15:0] sag_reg;
  logic [15:0] sag_next;
  logic [15:0] loss_reg;
  logic [15:0] loss_next;
  logic [15:0] ncalc_th_reg;
  logic [15:0] ncalc_th_next;
  logic [15:0] nsamp_th_reg;
  logic [15:0] nsamp_th_next;
  logic [15:0] status_reg;
  logic [15:0] status_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic irq_reg;
  logic irq_next;
  logic sag_flag_reg;
  logic sag_flag_next;
  logic loss_flag_reg;
  logic loss_flag_next;
  logic [15:0] status_set;
  logic [15:0] status_clr;

  // One carrier per crossing pin
  zc_pin_if zc_bus[3] ();

  // Strict less-than: a phase sitting exactly on a threshold is not flagged
  function automatic logic any_below(input logic [15:0] a, input logic [15:0] b,
                                     input logic [15:0] c, input logic [15:0] th);
    any_below = (a < th) || (b < th) || (c < th);
  endfunction

  // Index match for a write strobe; reads keep their own decode
  function automatic logic wr_hit(input logic [6:0] addr, input logic [6:0] target,
                                  input logic wr);
    wr_hit = wr && (addr == target);
  endfunction

  // Register writes
  always_comb
  begin
    enable_next = enable_reg;
    zc_cfg_next = zc_cfg_reg;
    sag_next = sag_reg;
    loss_next = loss_reg;
    ncalc_th_next = ncalc_th_reg;
    nsamp_th_next = nsamp_th_reg;
    // Reserved enable bits are masked here so they can never raise the interrupt
    if (wr_hit(i_reg_addr, event_regs_pkg::ADDR_EVENT_IRQ_ENABLE_B, i_reg_wr))
    begin
      enable_next = i_reg_wdata & event_regs_pkg::EVENT_BITS_MASK;
    end
    if (wr_hit(i_reg_addr, event_regs_pkg::ADDR_ZERO_CROSS_CONFIG, i_reg_wr))
    begin
      zc_cfg_next = i_reg_wdata;
    end
    if (wr_hit(i_reg_addr, event_regs_pkg::ADDR_SAG_THRESHOLD, i_reg_wr))
    begin
      sag_next = i_reg_wdata;
    end
    if (wr_hit(i_reg_addr, event_regs_pkg::ADDR_PHASE_LOSS_THRESHOLD, i_reg_wr))
    begin
      loss_next = i_reg_wdata;
    end
    if (wr_hit(i_reg_addr, event_regs_pkg::ADDR_NEUTRAL_CALC_WARN_THRESHOLD, i_reg_wr))
    begin
      ncalc_th_next = i_reg_wdata;
    end
    if (wr_hit(i_reg_addr, event_regs_pkg::ADDR_NEUTRAL_SAMPLED_WARN_THRESHOLD, i_reg_wr))
    begin
      nsamp_th_next = i_reg_wdata;
    end
  end

  // Status word b, sticky; a read clears what it returned, but a new set wins
  always_comb
  begin
    status_set = 16'h0000;
    // Neutral compares use the thresholds held before a write in this same cycle
    if (i_rms_valid)
    begin
      status_set[event_regs_pkg::BIT_NEUTRAL_SAMPLED_OVER] =
        (i_neutral_sampled_rms > nsamp_th_reg);
      status_set[event_regs_pkg::BIT_NEUTRAL_CALC_OVER] =
        (i_neutral_calc_rms > ncalc_th_reg);
    end
    status_set[event_regs_pkg::BIT_VOLTAGE_DISTORTION_OVER] = i_voltage_distortion_over;
    status_set[event_regs_pkg::BIT_CURRENT_DISTORTION_OVER] = i_current_distortion_over;
    status_set[event_regs_pkg::BIT_HARMONIC_RESULT_READY] = i_harmonic_result_ready;
    status_set[event_regs_pkg::BIT_DIR_CHANGE_MSB:event_regs_pkg::BIT_DIR_CHANGE_LSB] =
      i_dir_change;
    // A read clears exactly the bits that it returns
    status_clr = 16'h0000;
    if (i_reg_rd && (i_reg_addr == event_regs_pkg::ADDR_STATUS_WORD_B))
    begin
      status_clr = status_reg;
    end
    status_next = ((status_reg & ~status_clr) | status_set) & event_regs_pkg::EVENT_BITS_MASK;
  end

  // Interrupt from the registered status and enables
  always_comb
  begin
    // One cycle of latency is traded for a glitch-free pin
    irq_next = |(status_reg & enable_reg);
  end

  // Voltage level flags refresh on each measurement strobe
  always_comb
  begin
    sag_flag_next = sag_flag_reg;
    loss_flag_next = loss_flag_reg;
    if (i_rms_valid)
    begin
      sag_flag_next = any_below(i_volt_rms_a, i_volt_rms_b, i_volt_rms_c, sag_reg);
      loss_flag_next = any_below(i_volt_rms_a, i_volt_rms_b, i_volt_rms_c, loss_reg);
    end
  end

  // Read answer one cycle after the strobe; unmapped indices read zero
  // Back-to-back reads are fine: each strobe gets its own answer cycle
  always_comb
  begin
    rvalid_next = i_reg_rd;
    rdata_next = 16'h0000;
    if (i_reg_rd)
    begin
      unique case (i_reg_addr)
        event_regs_pkg::ADDR_STATUS_WORD_B: rdata_next = status_reg;
        event_regs_pkg::ADDR_EVENT_IRQ_ENABLE_B: rdata_next = enable_reg;
        event_regs_pkg::ADDR_ZERO_CROSS_CONFIG: rdata_next = zc_cfg_reg;
        event_regs_pkg::ADDR_SAG_THRESHOLD: rdata_next = sag_reg;
        event_regs_pkg::ADDR_PHASE_LOSS_THRESHOLD: rdata_next = loss_reg;
        event_regs_pkg::ADDR_NEUTRAL_CALC_WARN_THRESHOLD: rdata_next = ncalc_th_reg;
        event_regs_pkg::ADDR_NEUTRAL_SAMPLED_WARN_THRESHOLD: rdata_next = nsamp_th_reg;
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  // Configuration registers; a write lands at the edge that takes it
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      enable_reg <= event_regs_pkg::RST_EVENT_IRQ_ENABLE_B;
      zc_cfg_reg <= event_regs_pkg::RST_ZERO_CROSS_CONFIG;
      sag_reg <= event_regs_pkg::RST_SAG_THRESHOLD;
      loss_reg <= event_regs_pkg::RST_PHASE_LOSS_THRESHOLD;
      ncalc_th_reg <= event_regs_pkg::RST_NEUTRAL_WARN_THRESHOLD;
      nsamp_th_reg <= event_regs_pkg::RST_NEUTRAL_WARN_THRESHOLD;
    end
    else if (i_clk_en)
    begin
      enable_reg <= enable_next;
      zc_cfg_reg <= zc_cfg_next;
      sag_reg <= sag_next;
      loss_reg <= loss_next;
      ncalc_th_reg <= ncalc_th_next;
      nsamp_th_reg <= nsamp_th_next;
    end
  end

  // Status word b; only reset and reads clear it, writes never touch it
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      status_reg <= event_regs_pkg::RST_STATUS_WORD_B;
    end
    else if (i_clk_en)
    begin
      status_reg <= status_next;
    end
  end

  // Read answer; data falls back to zero once the answer has been shown
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      rdata_reg <= 16'h0000;
      rvalid_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // Interrupt pin
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      irq_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      irq_reg <= irq_next;
    end
  end

  // Voltage level flags; they hold between strobes so software reads a steady level
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      sag_flag_reg <= 1'b0;
      loss_flag_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      sag_flag_reg <= sag_flag_next;
      loss_flag_reg <= loss_flag_next;
    end
  end

  // Pin n takes its fields at fixed strides from the pin 0 positions
  for (genvar p = 0; p < event_regs_pkg::ZC_PINS; p++)
  begin : g_zc
    assign zc_bus[p].source = zc_cfg_reg[event_regs_pkg::ZC_SRC_LSB_PIN0 +
      p * event_regs_pkg::ZC_SRC_W +: event_regs_pkg::ZC_SRC_W];
    assign zc_bus[p].mode = zc_cfg_reg[event_regs_pkg::ZC_MODE_LSB_PIN0 +
      p * event_regs_pkg::ZC_MODE_W +: event_regs_pkg::ZC_MODE_W];
    // All pins share the one off bit, so a single write silences every pin
    assign zc_bus[p].off = zc_cfg_reg[event_regs_pkg::ZC_OFF_BIT];
    zero_cross_pin u_pin (
      .i_sys_clk(i_sys_clk),
      .i_rst_b(i_rst_b),
      .i_clk_en(i_clk_en),
      .i_wave_sign(i_wave_sign),
      .cfg(zc_bus[p])
    );
    assign o_zc[p] = zc_bus[p].zc_out;
  end

  assign o_reg_rdata = rdata_reg;
  assign o_reg_rvalid = rvalid_reg;
  assign o_irq_out_b = irq_reg;
  assign o_undervoltage_flag = sag_flag_reg;
  assign o_phase_loss_flag = loss_flag_reg;
endmodule

// ### event_regs_pkg.sv
// Purpose: Shared constants for the event enable, zero-crossing and threshold registers
// Assumes: 7-bit register index on the serial register port, 16-bit data
// Notes: Offsets are register indices as seen by the register port
package event_regs_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int ZC_PINS = 3;
  localparam int WAVES = 6;

  // Register indices
  localparam logic [6:0] ADDR_STATUS_WORD_B = 7'h02;
  localparam logic [6:0] ADDR_EVENT_IRQ_ENABLE_B = 7'h04;
  localparam logic [6:0] ADDR_ZERO_CROSS_CONFIG = 7'h07;
  localparam logic [6:0] ADDR_SAG_THRESHOLD = 7'h08;
  localparam logic [6:0] ADDR_PHASE_LOSS_THRESHOLD = 7'h09;
  localparam logic [6:0] ADDR_NEUTRAL_CALC_WARN_THRESHOLD = 7'h0a;
  localparam logic [6:0] ADDR_NEUTRAL_SAMPLED_WARN_THRESHOLD = 7'h0b;

  // Reset values
  localparam logic [15:0] RST_EVENT_IRQ_ENABLE_B = 16'h0000;
  localparam logic [15:0] RST_ZERO_CROSS_CONFIG = 16'h0001;
  localparam logic [15:0] RST_SAG_THRESHOLD = 16'h0000;
  localparam logic [15:0] RST_PHASE_LOSS_THRESHOLD = 16'h0000;
  localparam logic [15:0] RST_NEUTRAL_WARN_THRESHOLD = 16'hffff;
  localparam logic [15:0] RST_STATUS_WORD_B = 16'h0000;

  // Implemented bits of the enable and status words; 13:12 and 8 are reserved
  localparam logic [15:0] EVENT_BITS_MASK = 16'hceff;

  // Bit positions in the enable and status words
  localparam int BIT_NEUTRAL_SAMPLED_OVER = 15;
  localparam int BIT_NEUTRAL_CALC_OVER = 14;
  localparam int BIT_VOLTAGE_DISTORTION_OVER = 11;
  localparam int BIT_CURRENT_DISTORTION_OVER = 10;
  localparam int BIT_HARMONIC_RESULT_READY = 9;
  localparam int BIT_DIR_CHANGE_MSB = 7;
  localparam int BIT_DIR_CHANGE_LSB = 0;

  // Zero-crossing configuration layout
  localparam int ZC_SRC_LSB_PIN0 = 7;
  localparam int ZC_SRC_W = 3;
  localparam int ZC_MODE_LSB_PIN0 = 1;
  localparam int ZC_MODE_W = 2;
  localparam int ZC_OFF_BIT = 0;

  // Source codes: bit 2 selects current, low bits select the phase; 011 and 111 are fixed 0
  localparam logic [1:0] ZC_PHASE_NONE = 2'h3;

  // Edge modes
  localparam logic [1:0] ZC_MODE_POS = 2'h0;
  localparam logic [1:0] ZC_MODE_NEG = 2'h1;
  localparam logic [1:0] ZC_MODE_ALL = 2'h2;
  localparam logic [1:0] ZC_MODE_NONE = 2'h3;
endpackage

// ### zc_pin_if.sv
// Purpose: Configuration and result of one zero-crossing pin generator
// Assumes: Driven by the register bank, consumed by zero_cross_pin
// Notes: None
`timescale 1ns/1ps
interface zc_pin_if;
  logic [2:0] source;
  logic [1:0] mode;
  logic off;
  logic zc_out;
  modport bank (output source, output mode, output off, input zc_out);
  modport pin (input source, input mode, input off, output zc_out);
endinterface

// ### zero_cross_pin.sv
// Purpose: Zero-crossing pulse generator for one output pin
// Assumes: Wave sign bits are on the system clock, 1 means negative
// Notes: Index 0..2 voltage A..C, 3..5 current A..C
`timescale 1ns/1ps
module zero_cross_pin (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Wave signs
  input wire logic [5:0] i_wave_sign,
  // Configuration and pulse
  zc_pin_if.pin cfg
);
  logic sel_sign;
  logic sel_valid;
  logic prev_reg;
  logic prev_next;
  logic out_reg;
  logic out_next;
  logic rise_pos;
  logic rise_neg;

  always_comb
  begin
    sel_valid = (cfg.source[1:0] != event_regs_pkg::ZC_PHASE_NONE);
    sel_sign = 1'b0;
    if (sel_valid)
    begin
      // Currents sit three places above the voltages in the sign vector
      sel_sign = i_wave_sign[{1'b0, cfg.source[1:0]} + (cfg.source[2] ? 3'h3 : 3'h0)];
    end
    rise_pos = prev_reg & ~sel_sign;
    rise_neg = ~prev_reg & sel_sign;
    prev_next = sel_sign;
    out_next = 1'b0;
    unique case (cfg.mode)
      event_regs_pkg::ZC_MODE_POS: out_next = rise_pos;
      event_regs_pkg::ZC_MODE_NEG: out_next = rise_neg;
      event_regs_pkg::ZC_MODE_ALL: out_next = rise_pos | rise_neg;
      event_regs_pkg::ZC_MODE_NONE: out_next = 1'b0;
    endcase
    // Fixed-0 source or global off silences the pin
    if (!sel_valid || cfg.off)
    begin
      out_next = 1'b0;
    end
  end

  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      prev_reg <= 1'b0;
      out_reg <= 1'b0;
    end
    else if (i_clk_en)
    begin
      prev_reg <= prev_next;
      out_reg <= out_next;
    end
  end

  assign cfg.zc_out = out_reg;
endmodule

// ### event_regs_checker.sv
// Purpose: Port-level checks for the event enable, zero-crossing and threshold bank
// Assumes: Shadows follow accepted writes exactly as the bank decodes them
// Notes: A write and a strobe in one cycle compare against the old threshold
`timescale 1ns/1ps
module event_regs_checker (
  // Clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  input wire logic i_clk_en,
  // Register port
  input wire logic [6:0] i_reg_addr,
  input wire logic i_reg_wr,
  input wire logic i_reg_rd,
  input wire logic [15:0] i_reg_wdata,
  input wire logic [15:0] o_reg_rdata,
  input wire logic o_reg_rvalid,
  // Measurements
  input wire logic i_rms_valid,
  input wire logic [15:0] i_volt_rms_a,
  input wire logic [15:0] i_volt_rms_b,
  input wire logic [15:0] i_volt_rms_c,
  // Outputs
  input wire logic o_irq_out_b,
  input wire logic o_undervoltage_flag,
  input wire logic o_phase_loss_flag,
  input wire logic [2:0] o_zc
);
  logic [15:0] en_sh, sag_sh, loss_sh;
  logic off_sh;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_b);
  always_ff @(posedge i_sys_clk)
  begin
    if (!i_rst_b)
    begin
      en_sh <= 16'h0000;
      sag_sh <= 16'h0000;
      loss_sh <= 16'h0000;
      off_sh <= 1'h1;
    end
    else if (i_reg_wr && i_clk_en)
    begin
      if (i_reg_addr == 7'h04)
        en_sh <= i_reg_wdata & event_regs_pkg::EVENT_BITS_MASK;
      if (i_reg_addr == 7'h07)
        off_sh <= i_reg_wdata[0];
      if (i_reg_addr == 7'h08)
        sag_sh <= i_reg_wdata;
      if (i_reg_addr == 7'h09)
        loss_sh <= i_reg_wdata;
    end
  end
  chk_read_answer: assert property (i_reg_rd && i_clk_en |=> o_reg_rvalid)
    else $error("read got no answer");
  chk_rvalid_cause: assert property (o_reg_rvalid && $past(i_clk_en) |-> $past(i_reg_rd))
    else $error("answer without read");
  chk_rdata_idle: assert property (!o_reg_rvalid |-> o_reg_rdata == 16'h0000)
    else $error("read data not zero when idle");
  chk_irq_masked: assert property ($past(i_clk_en) && $past(en_sh) == 16'h0000 |->
    !o_irq_out_b)
    else $error("interrupt with all enables clear");
  chk_zc_off_quiet: assert property (off_sh && $past(off_sh) |-> o_zc == 3'h0)
    else $error("crossing pulse while outputs off");
  chk_sag_value: assert property (i_rms_valid && i_clk_en |=> o_undervoltage_flag ==
    ($past(i_volt_rms_a) < $past(sag_sh) || $past(i_volt_rms_b) < $past(sag_sh) ||
    $past(i_volt_rms_c) < $past(sag_sh)))
    else $error("sag flag wrong");
  chk_loss_value: assert property (i_rms_valid && i_clk_en |=> o_phase_loss_flag ==
    ($past(i_volt_rms_a) < $past(loss_sh) || $past(i_volt_rms_b) < $past(loss_sh) ||
    $past(i_volt_rms_c) < $past(loss_sh)))
    else $error("phase loss flag wrong");
  chk_flags_hold: assert property (!$past(i_rms_valid) |->
    $stable(o_undervoltage_flag) && $stable(o_phase_loss_flag))
    else $error("voltage flag moved without strobe");
endmodule
bind event_enable_zx_threshold_regs event_regs_checker event_regs_checker_i (.i_sys_clk,
  .i_rst_b, .i_clk_en, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata,
  .o_reg_rvalid, .i_rms_valid, .i_volt_rms_a, .i_volt_rms_b, .i_volt_rms_c, .o_irq_out_b,
  .o_undervoltage_flag, .o_phase_loss_flag, .o_zc);

// ### event_enable_zx_threshold_regs_tb.sv
// Purpose: Self-checking bench for the event enable, zero-crossing and threshold bank
// Assumes: Clock enable held high; inputs change on the rising edge
// Notes: Wave signs idle positive so config writes raise no stray pulse
`timescale 1ns/1ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin mismatches++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (e)); end end
module event_enable_zx_threshold_regs_tb;
  logic i_sys_clk = 1'h0, i_rst_b = 1'h0, i_clk_en = 1'h1, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
  logic i_rms_valid = 1'h0, i_voltage_distortion_over = 1'h0, i_current_distortion_over = 1'h0;
  logic i_harmonic_result_ready = 1'h0;
  logic [6:0] i_reg_addr = 7'h0;
  logic [15:0] i_reg_wdata = 16'h0, i_volt_rms_a = 16'h0, i_volt_rms_b = 16'h0;
  logic [15:0] i_volt_rms_c = 16'h0, i_neutral_calc_rms = 16'h0, i_neutral_sampled_rms = 16'h0;
  logic [7:0] i_dir_change = 8'h0;
  logic [5:0] i_wave_sign = 6'h0;
  logic [15:0] o_reg_rdata;
  logic o_reg_rvalid, o_irq_out_b, o_undervoltage_flag, o_phase_loss_flag;
  logic [2:0] o_zc;
  int mismatches = 0, total_checks = 0, cycles = 0;
  localparam logic [6:0] ADR [8] = '{7'h04, 7'h07, 7'h08, 7'h09, 7'h0a, 7'h0b, 7'h02, 7'h7f};
  localparam logic [15:0] RSTV [8] = '{16'h0, 16'h1, 16'h0, 16'h0, 16'hffff, 16'hffff,
    16'h0, 16'h0};
  localparam logic [15:0] WRV [8] = '{16'h84a5, 16'hb5a5, 16'hb5a5, 16'hb5a5, 16'hb5a5, 16'hb5a5,
    16'h0, 16'h0};
  always #5 i_sys_clk = ~i_sys_clk;
  event_enable_zx_threshold_regs event_enable_zx_threshold_regs_i (.i_sys_clk, .i_rst_b,
    .i_clk_en, .i_reg_addr, .i_reg_wr, .i_reg_rd, .i_reg_wdata, .o_reg_rdata, .o_reg_rvalid,
    .i_rms_valid, .i_volt_rms_a, .i_volt_rms_b, .i_volt_rms_c, .i_neutral_calc_rms,
    .i_neutral_sampled_rms, .i_voltage_distortion_over, .i_current_distortion_over,
    .i_harmonic_result_ready, .i_dir_change, .i_wave_sign, .o_irq_out_b, .o_undervoltage_flag,
    .o_phase_loss_flag, .o_zc);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge i_sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      print_verdict();
    end
  end
  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_wdata <= d;
    i_reg_wr <= 1'h1;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [6:0] a, input logic [15:0] e);
    @(posedge i_sys_clk);
    i_reg_addr <= a;
    i_reg_rd <= 1'h1;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'h0;
    #1;
    `CHK(o_reg_rvalid, 1'h1)
    `CHK(o_reg_rdata, e)
  endtask
  // Bit 12 of ev is a bare rms strobe, since that status position is reserved
  task automatic pulse(input logic [15:0] ev, input logic [15:0] v);
    @(posedge i_sys_clk);
    i_rms_valid <= ev[15] | ev[14] | ev[12];
    i_neutral_sampled_rms <= ev[15] ? v : 16'h0;
    i_neutral_calc_rms <= ev[14] ? v : 16'h0;
    i_voltage_distortion_over <= ev[11];
    i_current_distortion_over <= ev[10];
    i_harmonic_result_ready <= ev[9];
    i_dir_change <= ev[7:0];
    @(posedge i_sys_clk);
    i_rms_valid <= 1'h0;
    i_voltage_distortion_over <= 1'h0;
    i_current_distortion_over <= 1'h0;
    i_harmonic_result_ready <= 1'h0;
    i_dir_change <= 8'h0;
  endtask
  task automatic sag(input logic [15:0] a, b, c, input logic eu, ep);
    @(posedge i_sys_clk);
    i_volt_rms_a <= a;
    i_volt_rms_b <= b;
    i_volt_rms_c <= c;
    pulse(16'h1000, 16'h0);
    #1;
    `CHK(o_undervoltage_flag, eu)
    `CHK(o_phase_loss_flag, ep)
  endtask
  task automatic zc_cnt(input int p, output logic [1:0] n);
    n = 2'h0;
    repeat (3)
    begin
      @(posedge i_sys_clk);
      #1;
      n = n + o_zc[p];
    end
  endtask
  task automatic zc_run(input int p, input logic [15:0] cfg, input logic [5:0] w,
    input logic [1:0] en, ep);
    logic [1:0] n;
    wr(7'h07, cfg);
    repeat (2) @(posedge i_sys_clk);
    i_wave_sign <= w;
    zc_cnt(p, n);
    `CHK(n, en)
    @(posedge i_sys_clk);
    i_wave_sign <= 6'h0;
    zc_cnt(p, n);
    `CHK(n, ep)
  endtask
  initial
  begin
    repeat (12) @(posedge i_sys_clk);
    i_rst_b <= 1'h1;
    for (int i = 0; i < 8; i++) rd(ADR[i], RSTV[i]);
    for (int i = 0; i < 8; i++) wr(ADR[i], 16'hb5a5);
    for (int i = 0; i < 8; i++) rd(ADR[i], WRV[i]);
    wr(7'h08, 16'h1000);
    wr(7'h09, 16'h0800);
    wr(7'h0a, 16'h0100);
    wr(7'h0b, 16'h0100);
    sag(16'h1000, 16'h2000, 16'h0fff, 1'h1, 1'h0);
    sag(16'h1000, 16'h1000, 16'h07ff, 1'h1, 1'h1);
    sag(16'h0800, 16'h1000, 16'h1000, 1'h1, 1'h0);
    sag(16'h1000, 16'h1000, 16'h1000, 1'h0, 1'h0);
    // Neutral bits see an rms equal to the threshold first, which must not count
    for (int b = 0; b < 16; b++)
      if (event_regs_pkg::EVENT_BITS_MASK[b])
      begin
        wr(7'h04, 16'h1 << b);
        pulse(16'h1 << b, 16'h0100);
        repeat (3) @(posedge i_sys_clk);
        #1;
        `CHK(o_irq_out_b, b < 14)
        rd(7'h02, b < 14 ? 16'h1 << b : 16'h0);
        pulse(16'h1 << b, 16'h0101);
        repeat (2) @(posedge i_sys_clk);
        #1;
        `CHK(o_irq_out_b, 1'h1)
        rd(7'h02, 16'h1 << b);
        @(posedge i_sys_clk);
        #1;
        `CHK(o_irq_out_b, 1'h0)
      end
    wr(7'h04, 16'h0);
    pulse(16'h0200, 16'h0);
    repeat (3) @(posedge i_sys_clk);
    #1;
    `CHK(o_irq_out_b, 1'h0)
    rd(7'h02, 16'h0200);
    for (int p = 0; p < 3; p++)
      for (int s = 0; s < 8; s++)
        for (int m = 0; m < 4; m++)
          zc_run(p, 16'((16'h007e & ~(16'h3 << (1 + 2 * p))) | (s << (7 + 3 * p)) |
            (m << (1 + 2 * p))), s % 4 == 3 ? 6'h3f : 6'h1 << ((s / 4) * 3 + s % 4),
            2'(s % 4 != 3 && (m == 1 || m == 2)), 2'(s % 4 != 3 && (m == 0 || m == 2)));
    zc_run(0, 16'h0005, 6'h01, 2'h0, 2'h0);
    // A reset in mid-run must bring the enable, crossing config and sampled neutral threshold back to their reset values
    @(posedge i_sys_clk);
    i_rst_b <= 1'h0;
    repeat (2) @(posedge i_sys_clk);
    i_rst_b <= 1'h1;
    rd(7'h04, 16'h0000);
    rd(7'h07, 16'h0001);
    rd(7'h0b, 16'hffff);
    print_verdict();
  end
endmodule
